// ===== bench/pdc_port_dev_ctl_monitor.sv
// assertions on the port device control bank ports
// assumes bind onto pdc_port_dev_ctl; one clock, sync reset
`timescale 1ns/1ps
`default_nettype none
module pdc_port_dev_ctl_monitor (
    input wire logic clk,
    input wire logic reset,
    input wire pdc_pkg::pdc_err_t errorEvent,
    input wire pdc_pkg::pdc_err_t errorReport,
    input wire logic [8:0] maxPayloadBytes,
    input wire logic originateRelaxedOrdering,
    input wire logic originateNoSnoop,
    input wire logic irq,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata
);
    import pdc_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    no_relaxed_a: assert property (!originateRelaxedOrdering)
        else $error("relaxed ordering originated");
    no_snoop_a: assert property (!originateNoSnoop)
        else $error("no snoop originated");
    payload_bytes_a: assert property (
        maxPayloadBytes == 9'h080 || maxPayloadBytes == 9'h100)
        else $error("payload size not 128 or 256");
    report_cause_a: assert property ((errorReport & ~$past(errorEvent)) == 4'h0)
        else $error("report without event");
    rdata_hold_a: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("upper read bits set");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped");
    bresp_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer repeated");
    cover property (errorReport != 4'h0);
    cover property ($rose(irq));
    cover property (maxPayloadBytes == 9'h100);
endmodule // pdc_port_dev_ctl_monitor
`default_nettype wire

// ===== bench/pdc_port_dev_ctl_tb.sv
// self-checking bench for the port device control bank
// assumes pdc_defs.svh and pdc_pkg compiled first; one 125 MHz clock
`timescale 1ns/1ps
`default_nettype none
`include "pdc_defs.svh"
module pdc_port_dev_ctl_tb;
    import pdc_pkg::*;
    localparam logic [11:0] aCtl = {2'h0, `PDC_IDX_DEV_CTL, 2'h0};
    localparam logic [11:0] aSts = {2'h0, `PDC_IDX_DEV_STS, 2'h0};
    localparam logic [11:0] aIst = {2'h0, `PDC_IDX_IRQ_STS, 2'h0};
    localparam logic [11:0] aIcl = {2'h0, `PDC_IDX_IRQ_CLR, 2'h0};
    localparam logic [11:0] aIen = {2'h0, `PDC_IDX_IRQ_EN, 2'h0};
    localparam pdc_resp_t ok = `PDC_RESP_OKAY;
    localparam pdc_resp_t bad = `PDC_RESP_SLVERR;
    logic clk = 0, reset = 1, auxPowerOnReset = 1, auxPowerPin = 0, sequentialTagDebug = 0;
    pdc_err_t errorEvent = '0, errorReport;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    pdc_resp_t s_axi_bresp, s_axi_rresp, resp;
    logic [8:0] maxPayloadBytes;
    logic [7:0] debugTagMax;
    logic auxPowerPmEnable;
    int n_errors = 0, comparisons = 0, cyc = 0, ctl = 0, sts = 0, ist = 0, ien = 0, v;
    pdc_port_dev_ctl i_dut (.clk, .reset, .auxPowerOnReset, .auxPowerPin, .sequentialTagDebug,
        .errorEvent, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .errorReport, .maxPayloadBytes, .debugTagMax, .auxPowerPmEnable,
        .originateRelaxedOrdering(), .originateNoSnoop(), .irq);
    initial begin
        forever #4 clk = ~clk;
    end
    task automatic report_and_stop();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // whole run is well under this; a hung handshake lands here
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // ready is a flop, so it is looked at mid-cycle and acted on at the next edge
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input pdc_resp_t er);
        logic aw, w, b;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do begin
            @(negedge clk);
            aw = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            b = s_axi_bvalid;
            resp = s_axi_bresp;
            @(posedge clk);
            if (aw) s_axi_awvalid <= 0;
            if (w) s_axi_wvalid <= 0;
        end while (!b);
        s_axi_bready <= 0;
        @(posedge clk);
        chk(resp, er);
    endtask
    task automatic rdr(input logic [11:0] a, input logic [31:0] exp, input pdc_resp_t er);
        logic ar, r;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do begin
            @(negedge clk);
            ar = s_axi_arvalid && s_axi_arready;
            r = s_axi_rvalid;
            rd = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge clk);
            if (ar) s_axi_arvalid <= 0;
        end while (!r);
        s_axi_rready <= 0;
        @(posedge clk);
        chk(rd, exp);
        chk(resp, er);
    endtask
    task automatic rst();
        reset <= 1;
        @(posedge clk);
        reset <= 0;
        @(posedge clk);
    endtask
    initial begin
        v = $urandom(41);
        repeat (5) @(posedge clk);
        reset <= 0;
        auxPowerOnReset <= 0;
        rdr(aCtl, 0, ok);
        rdr(aSts, 0, ok);
        for (int c = 0; c < 8; c++) begin
            v = ($urandom & 32'hFFFFFF1F) | (c << 5);
            sequentialTagDebug <= v[9];
            wr(aCtl, v, ok);
            ctl = v & 32'h5EF;
            rdr(aCtl, ctl, ok);
            @(negedge clk);
            chk(maxPayloadBytes, c == 1 ? `PDC_BYTES_256 : `PDC_BYTES_128);
            chk(debugTagMax, v[9] && v[8] ? `PDC_TAG_MAX_WIDE : `PDC_TAG_MAX_NARROW);
            chk(auxPowerPmEnable, v[10]);
            @(posedge clk);
        end
        // enables stay random from the last pass, so the logging is seen with them off
        for (int k = 0; k < 6; k++) begin
            v = $urandom;
            errorEvent <= v[3:0];
            @(posedge clk);
            errorEvent <= '0;
            @(negedge clk);
            chk(errorReport, v[3:0] & ctl[3:0]);
            sts |= v[3:0];
            ist |= v[3:0];
            @(posedge clk);
            wr(aSts, v[7:4] | 32'hFFF0, ok);
            sts &= ~v[7:4];
            rdr(aSts, sts, ok);
        end
        ien = ($urandom & 32'hF) | 32'h1;
        wr(aIen, ien, ok);
        rdr(aIen, ien, ok);
        // one event on an enabled bit, so the level check can fail
        errorEvent <= 4'h1;
        @(posedge clk);
        errorEvent <= '0;
        ist |= 1;
        sts |= 1;
        rdr(aIst, ist, ok);
        @(negedge clk);
        chk(irq, (ist & ien) != 0);
        @(posedge clk);
        wr(aIcl, 32'hF, ok);
        rdr(aIcl, 0, ok);
        @(negedge clk);
        chk(irq, 0);
        @(posedge clk);
        auxPowerPin <= 1;
        wr(aCtl, 32'h400, ok);
        rdr(aSts, sts | 32'h10, ok);
        rst();
        rdr(aCtl, 32'h400, ok);
        auxPowerPin <= 0;
        repeat (3) @(posedge clk);
        rst();
        rdr(aCtl, 0, ok);
        wr(12'h1FC, $urandom, bad);
        rdr(12'h1FC, 0, bad);
        report_and_stop();
    end
endmodule // pdc_port_dev_ctl_tb
bind pdc_port_dev_ctl pdc_port_dev_ctl_monitor i_mon (.clk, .reset, .errorEvent, .errorReport,
    .maxPayloadBytes, .originateRelaxedOrdering, .originateNoSnoop, .irq, .s_axi_bvalid,
    .s_axi_bready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);
`default_nettype wire

// ===== core/pdc_port_dev_ctl.sv
// port device control and status registers behind an AXI4-Lite slave
// assumes error events are one-cycle pulses on clk; aux power pin is asynchronous
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "pdc_defs.svh"

module pdc_port_dev_ctl #(
    parameter int ADDR_W = 12,
    parameter logic [2:0] MAX_PAYLOAD_SUPPORTED = 3'h1
) (
    input wire logic clk,
    input wire logic reset,
    // cold power-up of the aux well; this, or port reset without aux power, clears the aux pm enable
    input wire logic auxPowerOnReset,
    input wire logic auxPowerPin,
    input wire logic sequentialTagDebug,
    input wire pdc_pkg::pdc_err_t errorEvent,
    // AXI4-Lite slave
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output pdc_pkg::pdc_resp_t s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output pdc_pkg::pdc_resp_t s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // block outputs
    output pdc_pkg::pdc_err_t errorReport,
    output logic [8:0] maxPayloadBytes,
    output logic [7:0] debugTagMax,
    output logic auxPowerPmEnable,
    output logic originateRelaxedOrdering,
    output logic originateNoSnoop,
    output logic irq
);
    import pdc_pkg::*;

    if (ADDR_W < 12 || ADDR_W > 32) begin : gBadAddrW
        $error("pdc_port_dev_ctl: ADDR_W must be 12 to 32");
    end
    if (MAX_PAYLOAD_SUPPORTED > 3'h1) begin : gBadMps
        $error("pdc_port_dev_ctl: only 128 or 256 byte payloads");
    end

    // decode used by both the write and the read path
    function automatic logic regHit(
        input logic [ADDR_W-1:0] a,
        input logic [7:0] idx
    );
        regHit = (a[9:2] == idx) && (a[ADDR_W-1:10] == '0);
    endfunction

    // aux power pin synchroniser
    logic auxMeta_q;
    logic auxSync_q;

    // control state
    pdc_err_t reportEnable_q;
    pdc_mps_t payloadSelect_q;
    logic wideTag_q;
    logic auxPm_q;
    logic auxPm_d;

    // status state
    pdc_err_t errorSeen_q;
    pdc_err_t errorSeen_d;
    pdc_err_t irqStatus_q;
    pdc_err_t irqStatus_d;
    pdc_err_t irqEnable_q;

    // bus state
    logic awHeld_q;
    logic awHeld_d;
    logic [ADDR_W-1:0] awAddr_q;
    logic wHeld_q;
    logic wHeld_d;
    logic [31:0] wData_q;
    logic [3:0] wStrb_q;
    logic awReady_q;
    logic wReady_q;
    logic bValid_q;
    logic bValid_d;
    pdc_resp_t bResp_q;
    logic arReady_q;
    logic rValid_q;
    logic rValid_d;
    logic [31:0] rData_q;
    pdc_resp_t rResp_q;

    // block output flops
    pdc_err_t errorReport_q;
    logic [8:0] payloadBytes_q;
    logic [7:0] tagMax_q;
    logic irq_q;

    // write channel
    wire awTake = s_axi_awvalid && awReady_q;
    wire wTake = s_axi_wvalid && wReady_q;
    wire doWrite = awHeld_q && wHeld_q && !bValid_q;
    wire hitCtlW = regHit(awAddr_q, `PDC_IDX_DEV_CTL);
    wire hitStsW = regHit(awAddr_q, `PDC_IDX_DEV_STS);
    wire hitIstW = regHit(awAddr_q, `PDC_IDX_IRQ_STS);
    wire hitIclW = regHit(awAddr_q, `PDC_IDX_IRQ_CLR);
    wire hitIenW = regHit(awAddr_q, `PDC_IDX_IRQ_EN);
    wire mappedW = hitCtlW || hitStsW || hitIstW || hitIclW || hitIenW;
    wire wrLo = doWrite && wStrb_q[0];
    wire wrHi = doWrite && wStrb_q[1];
    wire ctlLo = wrLo && hitCtlW;
    wire ctlHi = wrHi && hitCtlW;
    wire [3:0] errWr = wData_q[`PDC_STS_ERR_LSB +: 4];
    wire [3:0] stsClr = (wrLo && hitStsW) ? errWr : 4'h0;
    wire [3:0] irqClr = (wrLo && hitIclW) ? wData_q[3:0] : 4'h0;
    wire ienLo = wrLo && hitIenW;

    assign awHeld_d = doWrite ? 1'b0 : (awHeld_q || awTake);
    assign wHeld_d = doWrite ? 1'b0 : (wHeld_q || wTake);
    assign bValid_d = doWrite || (bValid_q && !s_axi_bready);

    // read channel
    wire arTake = s_axi_arvalid && arReady_q;
    wire hitCtlR = regHit(s_axi_araddr, `PDC_IDX_DEV_CTL);
    wire hitStsR = regHit(s_axi_araddr, `PDC_IDX_DEV_STS);
    wire hitIstR = regHit(s_axi_araddr, `PDC_IDX_IRQ_STS);
    wire hitIclR = regHit(s_axi_araddr, `PDC_IDX_IRQ_CLR);
    wire hitIenR = regHit(s_axi_araddr, `PDC_IDX_IRQ_EN);
    wire mappedR = hitCtlR || hitStsR || hitIstR || hitIclR || hitIenR;
    assign rValid_d = arTake || (rValid_q && !s_axi_rready);

    // readback images; fixed-zero fields are built in, not stored
    pdc_reg16_t ctlImage;
    pdc_reg16_t stsImage;
    always_comb begin
        ctlImage = `PDC_CTL_RESET;
        ctlImage[`PDC_CTL_ERR_LSB +: 4] = reportEnable_q;
        ctlImage[`PDC_CTL_RO_BIT] = 1'b0;
        ctlImage[`PDC_CTL_MPS_LSB +: 3] = payloadSelect_q;
        ctlImage[`PDC_CTL_WTAG_BIT] = wideTag_q;
        ctlImage[`PDC_CTL_PFN_BIT] = 1'b0;
        ctlImage[`PDC_CTL_AUXPM_BIT] = auxPm_q;
        ctlImage[`PDC_CTL_NS_BIT] = 1'b0;
        ctlImage[`PDC_CTL_MAX_READ_REQUEST_SIZE_LSB +: 3] = 3'h0;
        stsImage = `PDC_STS_RESET;
        stsImage[`PDC_STS_ERR_LSB +: 4] = errorSeen_q;
        stsImage[`PDC_STS_AUX_POWER_PRESENT_BIT] = auxSync_q;
        stsImage[`PDC_STS_TP_BIT] = 1'b0;
    end

    wire [31:0] rdMux =
        hitCtlR ? {16'h0000, ctlImage} :
        hitStsR ? {16'h0000, stsImage} :
        hitIstR ? {28'h0000000, irqStatus_q} :
        hitIenR ? {28'h0000000, irqEnable_q} :
        32'h00000000;

    // error logging; an event in the clearing cycle wins
    genvar gi;
    for (gi = 0; gi < 4; gi++) begin : gErr
        // logged whatever the enable holds
        assign errorSeen_d[gi] = (errorSeen_q[gi] && !stsClr[gi]) ||
            errorEvent[gi];
        assign irqStatus_d[gi] = (irqStatus_q[gi] && !irqClr[gi]) ||
            errorEvent[gi];
    end

    // reserved codes and unsupported 256 fall back to 128 bytes
    wire sel256 = (payloadSelect_q == `PDC_MPS_256) &&
        (MAX_PAYLOAD_SUPPORTED == `PDC_MPS_256);
    wire [8:0] payloadBytes_d = sel256 ? `PDC_BYTES_256 : `PDC_BYTES_128;
    // outside debug the range stays narrow: bit 8 has no effect then
    wire [7:0] tagMax_d = (sequentialTagDebug && wideTag_q) ?
        `PDC_TAG_MAX_WIDE : `PDC_TAG_MAX_NARROW;

    // the aux enable survives port reset only while aux power holds the well up
    always_comb begin
        auxPm_d = auxPm_q;
        if (auxPowerOnReset || (reset && !auxSync_q)) begin
            auxPm_d = 1'b0;
        end else if (ctlHi) begin
            auxPm_d = wData_q[`PDC_CTL_AUXPM_BIT];
        end
    end

    always_ff @(posedge clk) begin
        auxMeta_q <= auxPowerPin;
        auxSync_q <= auxMeta_q;
    end

    // port reset clears it only while aux power is absent
    always_ff @(posedge clk) begin
        auxPm_q <= auxPm_d;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            reportEnable_q <= 4'h0;
            payloadSelect_q <= `PDC_MPS_128;
            wideTag_q <= 1'b0;
        end else begin
            if (ctlLo) begin
                // only writable bits are stored
                reportEnable_q <= wData_q[`PDC_CTL_ERR_LSB +: 4];
                payloadSelect_q <= wData_q[`PDC_CTL_MPS_LSB +: 3];
            end
            if (ctlHi) begin
                wideTag_q <= wData_q[`PDC_CTL_WTAG_BIT];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            errorSeen_q <= 4'h0;
            irqStatus_q <= 4'h0;
            irqEnable_q <= 4'h0;
        end else begin
            errorSeen_q <= errorSeen_d;
            irqStatus_q <= irqStatus_d;
            if (ienLo) begin
                irqEnable_q <= wData_q[3:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            errorReport_q <= 4'h0;
            payloadBytes_q <= `PDC_BYTES_128;
            tagMax_q <= `PDC_TAG_MAX_NARROW;
            irq_q <= 1'b0;
        end else begin
            errorReport_q <= errorEvent & reportEnable_q;
            payloadBytes_q <= payloadBytes_d;
            tagMax_q <= tagMax_d;
            irq_q <= |(irqStatus_d & irqEnable_q);
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            awReady_q <= 1'b0;
            wReady_q <= 1'b0;
            bValid_q <= 1'b0;
            bResp_q <= `PDC_RESP_OKAY;
        end else begin
            awHeld_q <= awHeld_d;
            wHeld_q <= wHeld_d;
            awReady_q <= !awHeld_d && !bValid_d;
            wReady_q <= !wHeld_d && !bValid_d;
            bValid_q <= bValid_d;
            if (doWrite) begin
                bResp_q <= mappedW ? `PDC_RESP_OKAY : `PDC_RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            awAddr_q <= '0;
            wData_q <= 32'h00000000;
            wStrb_q <= 4'h0;
        end else begin
            if (awTake) begin
                awAddr_q <= s_axi_awaddr;
            end
            if (wTake) begin
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            arReady_q <= 1'b0;
            rValid_q <= 1'b0;
            rData_q <= 32'h00000000;
            rResp_q <= `PDC_RESP_OKAY;
        end else begin
            arReady_q <= !rValid_d;
            rValid_q <= rValid_d;
            if (arTake) begin
                rData_q <= rdMux;
                rResp_q <= mappedR ? `PDC_RESP_OKAY : `PDC_RESP_SLVERR;
            end
        end
    end

    // never originated by this port
    logic zeroAttr_q;
    always_ff @(posedge clk) begin
        zeroAttr_q <= 1'b0;
    end

    assign s_axi_awready = awReady_q;
    assign s_axi_wready = wReady_q;
    assign s_axi_bvalid = bValid_q;
    assign s_axi_bresp = bResp_q;
    assign s_axi_arready = arReady_q;
    assign s_axi_rvalid = rValid_q;
    assign s_axi_rdata = rData_q;
    assign s_axi_rresp = rResp_q;
    assign errorReport = errorReport_q;
    assign maxPayloadBytes = payloadBytes_q;
    assign debugTagMax = tagMax_q;
    assign auxPowerPmEnable = auxPm_q;
    assign originateRelaxedOrdering = zeroAttr_q;
    assign originateNoSnoop = zeroAttr_q;
    assign irq = irq_q;
endmodule // pdc_port_dev_ctl

`default_nettype wire

// ===== pkg/pdc_defs.svh
// offsets, field positions, reset values and codes of the port device control bank
// assumes inclusion by bare name from design and bench files
`ifndef PDC_DEFS_SVH
`define PDC_DEFS_SVH
// register indices; byte address is four times the index
`define PDC_IDX_DEV_CTL 8'h48
`define PDC_IDX_DEV_STS 8'h4A
`define PDC_IDX_IRQ_STS 8'h60
`define PDC_IDX_IRQ_CLR 8'h61
`define PDC_IDX_IRQ_EN 8'h62
// control fields
`define PDC_CTL_ERR_LSB 0
`define PDC_CTL_RO_BIT 4
`define PDC_CTL_MPS_LSB 5
`define PDC_CTL_WTAG_BIT 8
`define PDC_CTL_PFN_BIT 9
`define PDC_CTL_AUXPM_BIT 10
`define PDC_CTL_NS_BIT 11
`define PDC_CTL_MAX_READ_REQUEST_SIZE_LSB 12
// status fields
`define PDC_STS_ERR_LSB 0
`define PDC_STS_AUX_POWER_PRESENT_BIT 4
`define PDC_STS_TP_BIT 5
// reset values
`define PDC_CTL_RESET 16'h0000
`define PDC_STS_RESET 16'h0000
// payload size codes and byte counts
`define PDC_MPS_128 3'h0
`define PDC_MPS_256 3'h1
`define PDC_BYTES_128 9'h080
`define PDC_BYTES_256 9'h100
// debug tag ranges
`define PDC_TAG_MAX_NARROW 8'h1F
`define PDC_TAG_MAX_WIDE 8'hFF
// AXI responses
`define PDC_RESP_OKAY 2'h0
`define PDC_RESP_SLVERR 2'h2
`endif

// ===== pkg/pdc_pkg.sv
// types shared by the port device control bank and its bench
// assumes pdc_defs.svh holds the numbers
package pdc_pkg;
    typedef logic [15:0] pdc_reg16_t;
    typedef logic [3:0] pdc_err_t;
    typedef logic [1:0] pdc_resp_t;
    typedef logic [2:0] pdc_mps_t;
endpackage
